// >>> src/flsu_pkg.sv
/*
  Shared constants, types and helper functions of the fan loop controller.
  Assumes a 40 MHz system clock and APB with 32-bit data.
*/
`default_nettype none
package flsu_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SPIN_BASE_MS  = 250;
  localparam int unsigned FAIL_BASE_UPD = 8;

  // ----------------------------------------
  // Register indices, byte address is 4 x index
  // ----------------------------------------
  localparam logic [9:0] IDX_GAIN = 10'h005;
  localparam logic [9:0] IDX_CFG  = 10'h006;
  localparam logic [9:0] IDX_STEP = 10'h007;
  localparam logic [9:0] IDX_CTRL = 10'h020;
  localparam logic [9:0] IDX_DIR  = 10'h021;
  localparam logic [9:0] IDX_STAT = 10'h022;
  localparam logic [9:0] IDX_DUTY = 10'h023;

  // Reset values
  localparam logic [5:0] GAIN_RST = 6'h2A;
  localparam logic [7:0] CFG_RST  = 8'h19;
  localparam logic [7:0] STEP_RST = 8'h10;
  localparam logic [7:0] CTRL_RST = 8'h1E;
  localparam logic [7:0] DIR_RST  = 8'h00;

  // Field positions
  localparam int GAIN_D_LSB = 4;
  localparam int GAIN_I_LSB = 2;
  localparam int GAIN_P_LSB = 0;
  localparam int CFG_WIN_LSB = 6;
  localparam int CFG_SKIP_FULL_KICK  = 5;
  localparam int CFG_LVL_LSB = 2;
  localparam int CFG_TIM_LSB = 0;
  localparam int CTRL_EN     = 0;
  localparam int CTRL_DO_LSB = 1;
  localparam int CTRL_UP_LSB = 3;
  localparam int CTRL_BS_LSB = 6;
  localparam int STAT_SPIN   = 0;
  localparam int STAT_DRV    = 1;

  // Drive scale
  localparam int DUTY_W = 10;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h3FF;
  localparam int unsigned LVL_BASE_PCT = 30;
  localparam int unsigned LVL_STEP_PCT = 5;
  localparam int unsigned PCT_FULL     = 100;

  // Spin-up sequence, Gray coded along idle-kick-level-run
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_KICK  = 2'b01,
    S_LEVEL = 2'b11,
    S_RUN   = 2'b10
  } flsu_state_t;

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  // Spin time in ms
  function automatic logic [10:0] spin_ms(input logic [1:0] c);
    return 11'(SPIN_BASE_MS << c);
  endfunction

  // Final spin drive on the 10-bit scale
  function automatic logic [9:0] level_duty(input logic [2:0] c);
    int unsigned pct;
    pct = LVL_BASE_PCT + LVL_STEP_PCT * int'(c);
    return 10'(pct * int'(DUTY_MAX) / PCT_FULL);
  endfunction

  // Update period in ms, code 2 filled at 300 ms
  function automatic logic [10:0] upd_ms(input logic [2:0] c);
    logic [10:0] v;
    v = 11'h064;
    unique case (c)
      3'h0: v = 11'h064;
      3'h1: v = 11'h0C8;
      3'h2: v = 11'h12C;
      3'h3: v = 11'h190;
      3'h4: v = 11'h1F4;
      3'h5: v = 11'h320;
      3'h6: v = 11'h4B0;
      3'h7: v = 11'h640;
    endcase
    return v;
  endfunction

  // Drive-fail window in update periods
  function automatic logic [6:0] fail_win(input logic [1:0] c);
    return 7'(FAIL_BASE_UPD << c);
  endfunction
endpackage
`default_nettype wire

// >>> src/flsu_tick.sv
/*
  Millisecond prescaler and update-period tick.
  Assumes MS_CYCLES clock cycles make one millisecond.
*/
`default_nettype none
module flsu_tick
  import flsu_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] upd_sel_i,
  output var  logic       ms_tick_o,
  output var  logic       upd_tick_o
);
  typedef struct packed {
    logic [15:0] pre;
    logic [10:0] ms;
    logic        ms_t;
    logic        up_t;
  } flsu_tick_t;

  flsu_tick_t r, n;

  // Count cycles into ms, ms into update periods
  always_comb begin
    n = r;
    n.ms_t = 1'b0;
    n.up_t = 1'b0;
    n.pre = r.pre + 16'h0001;
    if (r.pre >= 16'(MS_CYCLES - 1)) begin
      n.pre = 16'h0000;
      n.ms_t = 1'b1;
      n.ms = r.ms + 11'h001;
      if (r.ms + 11'h001 >= upd_ms(upd_sel_i)) begin
        n.ms = 11'h000;
        n.up_t = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ms_tick_o = r.ms_t;
  assign upd_tick_o = r.up_t;
endmodule
`default_nettype wire

// >>> src/flsu_pwm.sv
/*
  PWM output stage, 10-bit or 8-bit resolution.
  Assumes duty on the 10-bit scale; 8-bit mode uses its top byte.
*/
`default_nettype none
module flsu_pwm
  import flsu_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic [DUTY_W-1:0] duty_i,
  input  wire logic              mode8_i,
  output var  logic              pwm_o
);
  typedef struct packed {
    logic [DUTY_W-1:0] cnt;
    logic              out;
  } flsu_pwm_t;

  flsu_pwm_t r, n;

  // Free-running compare; full scale holds high
  always_comb begin
    n = r;
    n.cnt = r.cnt + 10'h001;
    if (mode8_i) begin
      n.out = (r.cnt[7:0] < duty_i[9:2]) || (duty_i == DUTY_MAX);
    end else begin
      n.out = (r.cnt < duty_i) || (duty_i == DUTY_MAX);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pwm_o = r.out;
endmodule
`default_nettype wire

// >>> src/flsu_fan_ctrl.sv
/*
  Fan loop controller: gains, spin-up routine, drive-fail window
  and per-update drive step limit, with an APB register slave.
  Assumes an outside tach block giving an error, a valid flag
  and a below-band flag, all synchronous to mclk_i.
*/
// The implementer's own choice: register access over APB.
`default_nettype none
module flsu_fan_ctrl
  import flsu_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output var  logic [31:0]        prdata_o,
  output var  logic               pready_o,
  output var  logic               pslverr_o,
  input  wire logic               tach_ok_i,
  input  wire logic signed [10:0] tach_err_i,
  input  wire logic               tach_below_i,
  output var  logic               pwm_o,
  output var  logic               spin_fail_o,
  output var  logic               drive_fail_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]        gain;
    logic [7:0]        cfg;
    logic [7:0]        step;
    logic [7:0]        ctrl;
    logic [7:0]        direct;
    logic              spin_fail;
    logic              drive_fail;
    flsu_state_t       st;
    logic [10:0]       el;
    logic [DUTY_W-1:0] duty;
    logic [10:0]       e_prev;
    logic [6:0]        fail_cnt;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } flsu_regs_t;

  flsu_regs_t r, n;

  logic              ms_tick;
  logic              upd_tick;
  logic              en;
  logic              skip;
  logic              mode8;
  logic              acc;
  logic              wr;
  logic              hit;
  logic              spin_end;
  logic              quarter_end;
  logic [1:0]        dopt;
  logic [1:0]        win_sel;
  logic [1:0]        gd;
  logic [1:0]        gi;
  logic [1:0]        gp;
  logic [7:0]        wb;
  logic [31:0]       rd;
  logic [9:0]        cap;
  logic [9:0]        lvl;
  logic [10:0]       sp_ms;
  logic signed [17:0] e;
  logic signed [17:0] de;
  logic signed [17:0] dterm;
  logic signed [17:0] delta;
  logic signed [17:0] cap_s;
  logic signed [17:0] dir_d;
  flsu_state_t       start_st;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clamp a change to plus or minus the cap
  function automatic logic signed [17:0] lim(input logic signed [17:0] d,
                                             input logic signed [17:0] c);
    logic signed [17:0] v;
    v = d;
    if (d > c) begin
      v = c;
    end else if (d < -c) begin
      v = -c;
    end
    return v;
  endfunction

  // Apply a change to the duty, saturating at both ends
  function automatic logic [DUTY_W-1:0] sat(input logic [DUTY_W-1:0] dty,
                                            input logic signed [17:0] d);
    logic signed [17:0] s;
    s = $signed({8'h00, dty}) + d;
    if (s < 18'sh0_0000) begin
      s = 18'sh0_0000;
    end else if (s > $signed({8'h00, DUTY_MAX})) begin
      s = $signed({8'h00, DUTY_MAX});
    end
    return s[DUTY_W-1:0];
  endfunction

  // Size of a duty change
  function automatic logic [DUTY_W-1:0] absd(input logic [DUTY_W-1:0] a,
                                             input logic [DUTY_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------
  // Field decode and loop arithmetic
  // ----------------------------------------
  assign en      = r.ctrl[CTRL_EN];
  assign dopt    = r.ctrl[CTRL_DO_LSB +: 2];
  assign mode8   = (r.ctrl[CTRL_BS_LSB +: 2] == 2'b00);
  assign skip    = r.cfg[CFG_SKIP_FULL_KICK];
  assign win_sel = r.cfg[CFG_WIN_LSB +: 2];
  assign gd      = r.gain[GAIN_D_LSB +: 2];
  assign gi      = r.gain[GAIN_I_LSB +: 2];
  assign gp      = r.gain[GAIN_P_LSB +: 2];
  assign sp_ms   = spin_ms(r.cfg[CFG_TIM_LSB +: 2]);
  assign lvl     = level_duty(r.cfg[CFG_LVL_LSB +: 3]);
  assign start_st = skip ? S_LEVEL : S_KICK;
  assign spin_end = ms_tick && (r.el == sp_ms - 11'h001);
  assign quarter_end = ms_tick && (r.el + 11'h001 >= (sp_ms >> 2));
  // Step on the active duty scale
  assign cap     = mode8 ? {r.step, 2'b00} : {2'b00, r.step};
  assign cap_s   = $signed({8'h00, cap});
  assign acc     = psel_i && penable_i;
  assign wr      = acc && r.pready && pwrite_i;
  assign wb      = pwdata_i[7:0];

  // Velocity-form terms, gain code is a shift of 0 to 3
  assign e       = 18'(tach_err_i);
  assign de      = e - 18'($signed(r.e_prev));
  assign dterm   = de <<< gd;
  assign delta   = (de <<< gp) + (e <<< gi)
                 + ((dopt != 2'b00) ? dterm : 18'sh0_0000)
                 + ((dopt == 2'b11) ? dterm : 18'sh0_0000);
  assign dir_d   = $signed({8'h00, r.direct, 2'b00}) - $signed({8'h00, r.duty});

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    case (paddr_i)
      reg_addr(IDX_GAIN): rd[5:0] = r.gain;
      reg_addr(IDX_CFG):  rd[7:0] = r.cfg;
      reg_addr(IDX_STEP): rd[7:0] = r.step;
      reg_addr(IDX_CTRL): rd[7:0] = r.ctrl;
      reg_addr(IDX_DIR):  rd[7:0] = r.direct;
      reg_addr(IDX_STAT): rd[3:0] = {r.st, r.drive_fail, r.spin_fail};
      reg_addr(IDX_DUTY): rd[DUTY_W-1:0] = r.duty;
      default:            hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    // APB: one wait cycle, data and error with ready
    n.pready = acc && !r.pready;
    if (acc && !r.pready) begin
      n.prdata = pwrite_i ? 32'h0000_0000 : rd;
      n.pslverr = !hit;
    end
    // Writes land on the edge that completes the access
    if (wr) begin
      case (paddr_i)
        reg_addr(IDX_GAIN): n.gain = wb[5:0];
        reg_addr(IDX_CFG):  n.cfg = wb;
        reg_addr(IDX_STEP): n.step = wb;
        reg_addr(IDX_CTRL): n.ctrl = wb;
        reg_addr(IDX_DIR):  n.direct = wb;
        reg_addr(IDX_STAT): begin
          if (wb[STAT_SPIN]) begin
            n.spin_fail = 1'b0;
          end
          if (wb[STAT_DRV]) begin
            n.drive_fail = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Spin-up and loop; hardware sets below win over clears
    if (!en) begin
      n.st = S_IDLE;
      n.el = 11'h000;
      n.fail_cnt = 7'h00;
      if (upd_tick) begin
        n.duty = sat(r.duty, lim(dir_d, cap_s));
      end
    end else begin
      unique case (r.st)
        S_IDLE: begin
          n.st = start_st;
          n.el = 11'h000;
        end
        S_KICK, S_LEVEL: begin
          if (ms_tick) begin
            n.el = r.el + 11'h001;
          end
          if (spin_end) begin
            n.el = 11'h000;
            if (tach_ok_i) begin
              n.st = S_RUN;
              n.duty = lvl;
              n.e_prev = tach_err_i;
            end else begin
              n.spin_fail = 1'b1;
              n.st = start_st;
            end
          end else if (r.st == S_KICK && quarter_end) begin
            n.st = S_LEVEL;
          end
        end
        S_RUN: begin
          if (!tach_ok_i) begin
            n.st = start_st;
            n.el = 11'h000;
          end else if (upd_tick) begin
            n.e_prev = tach_err_i;
            if (dopt[1]) begin
              n.duty = sat(r.duty, delta);
            end else begin
              n.duty = sat(r.duty, lim(delta, cap_s));
            end
            // Count updates stuck at full drive below target
            if (r.duty == DUTY_MAX && tach_below_i) begin
              n.fail_cnt = r.fail_cnt + 7'h01;
              if (r.fail_cnt + 7'h01 >= fail_win(win_sel)) begin
                n.drive_fail = 1'b1;
                n.fail_cnt = 7'h00;
              end
            end else begin
              n.fail_cnt = 7'h00;
            end
          end
        end
      endcase
    end
    // Spin phases force their drive
    if (n.st == S_KICK) begin
      n.duty = DUTY_MAX;
    end else if (n.st == S_LEVEL) begin
      n.duty = lvl;
    end
    if (win_sel == 2'b00) begin
      n.fail_cnt = 7'h00;
    end
  end

  // Register the whole state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.gain <= GAIN_RST;
      r.cfg <= CFG_RST;
      r.step <= STEP_RST;
      r.ctrl <= CTRL_RST;
      r.direct <= DIR_RST;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Sub-blocks and outputs
  // ----------------------------------------
  flsu_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .upd_sel_i  (r.ctrl[CTRL_UP_LSB +: 3]),
    .ms_tick_o  (ms_tick),
    .upd_tick_o (upd_tick)
  );

  flsu_pwm u_pwm (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .duty_i  (r.duty),
    .mode8_i (mode8),
    .pwm_o   (pwm_o)
  );

  assign prdata_o     = r.prdata;
  assign pready_o     = r.pready;
  assign pslverr_o    = r.pslverr;
  assign spin_fail_o  = r.spin_fail;
  assign drive_fail_o = r.drive_fail;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_GAIN_RSVD: assert property (
    (acc && !r.pready && !pwrite_i && paddr_i == reg_addr(IDX_GAIN))
    |=> (prdata_o[7:6] == 2'b00 && prdata_o[5:0] == $past(r.gain)))
    else $error("gain read bad");
  AST_GAIN_WR: assert property (
    (wr && paddr_i == reg_addr(IDX_GAIN)) |=> r.gain == $past(pwdata_i[5:0]))
    else $error("gain write lost");
  AST_KICK_FULL: assert property (
    (r.st == S_KICK) |-> (r.duty == DUTY_MAX && r.el < (sp_ms >> 2)))
    else $error("kick phase wrong");
  AST_NO_KICK: assert property (
    (skip && r.st != S_KICK) |=> r.st != S_KICK)
    else $error("kick with no-kick set");
  AST_LEVEL: assert property (
    (r.st == S_LEVEL && $stable(r.cfg)) |-> r.duty == lvl)
    else $error("spin level wrong");
  AST_SPIN_FAIL: assert property (
    (en && r.st inside {S_KICK, S_LEVEL} && spin_end && !tach_ok_i)
    |=> r.spin_fail)
    else $error("spin fail not flagged");
  AST_RETRY: assert property (
    (en && r.st inside {S_KICK, S_LEVEL} && spin_end && !tach_ok_i)
    |=> (r.st inside {S_KICK, S_LEVEL} && r.el == 11'h000))
    else $error("no retry");
  AST_STEP_CAP: assert property (
    (en && r.st == S_RUN && tach_ok_i && upd_tick && !dopt[1])
    |-> absd(n.duty, r.duty) <= cap)
    else $error("step over cap");
  AST_WIN_OFF: assert property (
    (win_sel == 2'b00) |=> r.fail_cnt == 7'h00)
    else $error("window off but counting");
  AST_FAIL_LOOP: assert property (
    (!en && !r.drive_fail) |=> !r.drive_fail)
    else $error("drive fail outside loop");

  COV_KICK_LEVEL: cover property (r.st == S_KICK ##1 r.st == S_LEVEL);
  COV_SPIN_FAIL: cover property ($rose(r.spin_fail));
  COV_DRIVE_FAIL: cover property ($rose(r.drive_fail));
  COV_UNCAPPED: cover property (r.st == S_RUN && upd_tick && dopt[1]);
endmodule
`default_nettype wire

// >>> verification/flsu_fan_model.sv
/*
  Behavioural fan with tachometer feedback.
  Assumes the bench says whether the rotor is free to turn.
*/
`default_nettype none
module flsu_fan_model (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               pwm_i,
  input  wire logic               spin_en_i,
  output var  logic               tach_ok_o,
  output var  logic signed [10:0] tach_err_o,
  output var  logic               tach_below_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int idle_cyc;

  // ----------------------------------------
  // Rotor: spins only while driven and free
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i || pwm_i) begin
      idle_cyc <= 0;
    end else if (idle_cyc < 4096) begin
      idle_cyc <= idle_cyc + 1;
    end
  end

  // A stalled or undriven rotor gives no valid reading
  assign tach_ok_o    = spin_en_i && idle_cyc < 2048;
  assign tach_err_o   = 11'sh000;
  assign tach_below_o = 1'b0;
endmodule
`default_nettype wire

// >>> verification/fan_loop_gain_spinup_step_tb_top.sv
/*
  Self-checking bench of the fan loop controller.
  Assumes MS_CYCLES of 4 and the fan model on the far side.
*/
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t %h vs %h", $time, a, b); end end
module fan_loop_gain_spinup_step_tb_top
  import flsu_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MSC = 4;
  localparam logic [11:0] AG = 12'h014, AC = 12'h018, AS = 12'h01C, AK = 12'h080;
  localparam logic [11:0] AD = 12'h084, AT = 12'h088, AU = 12'h08C;
  logic               mclk_i  = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic               spin_en = 1'b0;
  logic [11:0]        paddr   = 12'h000;
  logic [31:0]        pwdata  = 32'h0000_0000;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready, pslverr, er, tach_ok, tach_below, pwm, spin_fail, drive_fail;
  logic signed [10:0] tach_err;
  logic [7:0]         s;
  int                 err_total = 0;
  int                 checks    = 0;
  int                 exp_reg [int];

  flsu_fan_ctrl #(.MS_CYCLES(MSC)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tach_ok_i(tach_ok), .tach_err_i(tach_err),
    .tach_below_i(tach_below), .pwm_o(pwm), .spin_fail_o(spin_fail), .drive_fail_o(drive_fail));
  flsu_fan_model u_fan (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pwm_i(pwm), .spin_en_i(spin_en),
    .tach_ok_o(tach_ok), .tach_err_o(tach_err), .tach_below_o(tach_below));

  // ----------------------------------------
  // Bus tasks and register model
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Look at ready where it has settled, complete on the next rising edge
    do begin
      @(negedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED %0t bus timeout", $time);
    end
    @(posedge mclk_i);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, 32'(d));
    if (exp_reg.exists(a)) exp_reg[a] = d & (a == AG ? 8'h3F : 8'hFF);
  endtask

  task automatic chk(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, 32'(exp_reg[a]))
  endtask

  // Direct drive ramp: largest move per sample and end point
  task automatic ramp(input logic [7:0] ctl, input logic [7:0] dir, input int cap);
    int prv, cur, mx;
    wr(AK, ctl);
    wr(AD, dir);
    apb(1'b0, AU, 32'h0000_0000);
    prv = int'(rd[9:0]);
    mx  = 0;
    repeat (100) begin
      repeat (10 * MSC) @(posedge mclk_i);
      apb(1'b0, AU, 32'h0000_0000);
      cur = int'(rd[9:0]);
      mx  = (cur - prv > mx) ? cur - prv : (prv - cur > mx) ? prv - cur : mx;
      prv = cur;
    end
    `CHK(mx, cap)
    `CHK(rd[9:0], 10'(dir * 4))
  endtask

  // Spin-up with or without kick, fan stalled or free
  task automatic spin(input logic skip_full_kick, input logic ok);
    logic [2:0] lv;
    logic [9:0] lvd;
    lv  = 3'($urandom_range(7));
    lvd = 10'((30 + 5 * int'(lv)) * 1023 / 100);
    wr(AK, 8'h00);
    wr(AT, 8'h03);
    wr(AC, {2'b00, skip_full_kick, lv, 2'b00});
    spin_en <= ok;
    wr(AK, 8'h01);
    repeat (20 * MSC) @(posedge mclk_i);
    apb(1'b0, AU, 32'h0000_0000);
    `CHK(rd[9:0], skip_full_kick ? lvd : 10'h3FF)
    apb(1'b0, AT, 32'h0000_0000);
    `CHK(rd[3:0], skip_full_kick ? 4'b1100 : 4'b0100)
    repeat (100 * MSC) @(posedge mclk_i);
    apb(1'b0, AU, 32'h0000_0000);
    `CHK(rd[9:0], lvd)
    repeat (150 * MSC) @(posedge mclk_i);
    apb(1'b0, AT, 32'h0000_0000);
    `CHK(rd[3:0], ok ? 4'b1000 : {skip_full_kick ? 2'b11 : 2'b01, 2'b01})
    `CHK(spin_fail, !ok)
  endtask

  task automatic done(input string t);
    $display("test %0s done", t);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    $display("CHECK FAILED %0t watchdog", $time);
    stop_test();
  end

  initial begin
    void'($urandom(54));
    exp_reg[AG] = 8'h2A;
    exp_reg[AC] = 8'h19;
    exp_reg[AS] = 8'h10;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    chk(AG);
    chk(AC);
    chk(AS);
    done("reset values");
    wr(AG, 8'($urandom()));
    ramp(8'h00, 8'h80, 32'h40);
    done("ramp 8-bit");
    chk(AG);
    s = 8'($urandom_range(8'h7F, 8'h40));
    wr(AS, s);
    chk(AS);
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    done("registers");
    ramp(8'h40, 8'h00, int'(s));
    done("ramp 10-bit");
    spin(1'b0, 1'b0);
    done("stalled kick");
    spin(1'b1, 1'b1);
    done("free no kick");
    stop_test();
  end
endmodule
`default_nettype wire
